/* design/rdt_top.v */
// apb register bank: passive drive resistance and driver edge timing
// assumes transient ratio and rf period tick come from the analog driver
//
// Function
// - space A register: modulated and idle codes
// - decode code to normalized resistance, 15 high-z
// - space B register: ratio target, manual, code
// - target counts non-overlap times per rf period
// - auto: slowest first, speed up until reached
// - five settings, done within ten rf periods
// - manual bit selects manual or acquired timing
// - manual code decode, top bit set fast
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "rdt_defs.vh"
module rdt_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        driver_start,
    input  wire        rf_period_tick,
    input  wire [3:0]  measured_ratio,
    output reg  [2:0]  driver_speed,
    output reg  [3:0]  antenna_driver_output_mod_code,
    output reg  [3:0]  antenna_driver_output_idle_code,
    output reg  [11:0] mod_res_x10,
    output reg  [11:0] idle_res_x10,
    output reg         mod_hiz,
    output reg         idle_hiz,
    output reg         search_busy
);
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_MEAS = 2'b10;

    reg  [3:0]  mod_state_drive_code;
    reg  [3:0]  idle_state_drive_code;
    reg  [3:0]  ratio_target;
    reg         manual_sel;
    reg  [2:0]  manual_code;
    reg  [1:0]  state;
    reg  [2:0]  step;
    reg  [3:0]  periods;
    reg  [2:0]  acquired_speed;
    reg         search_done;
    reg  [2:0]  next_speed;

    // write lands at the access edge, while pready stands
    wire        wr_en = psel & penable & pwrite & pready;
    wire        rd_en = psel & ~penable;
    wire [11:0] mod_dec;
    wire [11:0] idle_dec;
    wire        mod_dec_hiz;
    wire        idle_dec_hiz;
    wire        mapped = (paddr == `RDT_OFF_RES) | (paddr == `RDT_OFF_TIM)
                       | (paddr == `RDT_OFF_STAT);

    function [2:0] manual_speed;
        input [2:0] c;
        begin
            case (c)
                3'h0: manual_speed = `RDT_SPD_SLOW;
                3'h1: manual_speed = `RDT_SPD_MSLOW;
                3'h2: manual_speed = `RDT_SPD_NOM;
                3'h3: manual_speed = `RDT_SPD_MFAST;
                default: manual_speed = `RDT_SPD_FAST;
            endcase
        end
    endfunction

    rdt_res_decode u_mod_dec (
        .code    (mod_state_drive_code),
        .res_x10 (mod_dec),
        .hiz     (mod_dec_hiz)
    );
    rdt_res_decode u_idle_dec (
        .code    (idle_state_drive_code),
        .res_x10 (idle_dec),
        .hiz     (idle_dec_hiz)
    );

    // apb slave, one wait-free access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_state_drive_code  <= 4'h7;
            idle_state_drive_code <= 4'h0;
            ratio_target          <= 4'h7;
            manual_sel            <= 1'b1;
            manual_code           <= 3'h4;
            prdata                <= 32'h00000000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (wr_en && paddr == `RDT_OFF_RES) begin
                mod_state_drive_code  <= pwdata[7:4];
                idle_state_drive_code <= pwdata[3:0];
            end
            if (wr_en && paddr == `RDT_OFF_TIM) begin
                ratio_target <= pwdata[7:4];
                manual_sel   <= pwdata[`RDT_MAN_BIT];
                manual_code  <= pwdata[2:0];
            end
            if (rd_en) begin
                case (paddr)
                    `RDT_OFF_RES: prdata <= {24'h000000,
                        mod_state_drive_code, idle_state_drive_code};
                    `RDT_OFF_TIM: prdata <= {24'h000000, ratio_target,
                        manual_sel, manual_code};
                    `RDT_OFF_STAT: prdata <= {26'h0000000, search_done,
                        search_busy, 1'b0, acquired_speed};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // automatic edge timing search
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ST_IDLE;
            step           <= 3'h0;
            periods        <= 4'h0;
            acquired_speed <= `RDT_SPD_SLOW;
            search_busy    <= 1'b0;
            search_done    <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (driver_start && !manual_sel) begin
                        state          <= ST_WAIT;
                        step           <= 3'h0;
                        periods        <= 4'h0;
                        acquired_speed <= `RDT_SPD_SLOW;
                        search_busy    <= 1'b1;
                        search_done    <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    // settle one rf period on the new speed
                    if (rf_period_tick) begin
                        periods <= periods + 4'h1;
                        state   <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (rf_period_tick) begin
                        periods <= periods + 4'h1;
                        // ratio counts both edges' non-overlap per period
                        if (measured_ratio >= ratio_target ||
                            step == `RDT_STEPS - 3'h1 ||
                            periods >= `RDT_MAX_PERIODS - 4'h1) begin
                            state       <= ST_IDLE;
                            search_busy <= 1'b0;
                            search_done <= 1'b1;
                        end else begin
                            step           <= step + 3'h1;
                            acquired_speed <= step + 3'h1;
                            state          <= ST_WAIT;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always @* begin
        next_speed = manual_sel ? manual_speed(manual_code)
                                : acquired_speed;
    end

    // codes taken as written; software orders them before the mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_speed                    <= `RDT_SPD_FAST;
            antenna_driver_output_mod_code  <= 4'h7;
            antenna_driver_output_idle_code <= 4'h0;
            mod_res_x10                     <= 12'h140;
            idle_res_x10                    <= 12'h00A;
            mod_hiz                         <= 1'b0;
            idle_hiz                        <= 1'b0;
        end else begin
            driver_speed                    <= next_speed;
            antenna_driver_output_mod_code  <= mod_state_drive_code;
            antenna_driver_output_idle_code <= idle_state_drive_code;
            mod_res_x10                     <= mod_dec;
            idle_res_x10                    <= idle_dec;
            mod_hiz                         <= mod_dec_hiz;
            idle_hiz                        <= idle_dec_hiz;
        end
    end
endmodule // rdt_top

/* pkg/rdt_defs.vh */
// constants for the driver resistance and edge timing register bank
// assumes inclusion by bare name from design files
`ifndef RDT_DEFS_VH
`define RDT_DEFS_VH
`define RDT_ADDR_A         8'h29
`define RDT_ADDR_B         8'h29
`define RDT_SPACE_BIT      8
`define RDT_OFF_RES        12'h0A4
`define RDT_OFF_TIM        12'h1A4
`define RDT_OFF_CTRL       12'h200
`define RDT_OFF_STAT       12'h204
`define RDT_RES_RST        8'h70
`define RDT_TIM_RST        8'h7C
`define RDT_MAN_BIT        3
`define RDT_STEPS          3'h5
`define RDT_MAX_PERIODS    4'hA
`define RDT_CODE_HIZ       4'hF
`define RDT_SPD_SLOW       3'h0
`define RDT_SPD_MSLOW      3'h1
`define RDT_SPD_NOM        3'h2
`define RDT_SPD_MFAST      3'h3
`define RDT_SPD_FAST       3'h4
`endif

/* design/rdt_res_decode.v */
// decoder of a 4-bit passive drive code to normalized resistance
// output is resistance times 10, in 12 bits; high-z flagged separately
`timescale 1ns/10ps
`include "rdt_defs.vh"
module rdt_res_decode (
    input  wire [3:0]  code,
    output reg  [11:0] res_x10,
    output wire        hiz
);
    assign hiz = (code == `RDT_CODE_HIZ);
    always @* begin
        case (code)
            4'h0: res_x10 = 12'h00A;
            4'h1: res_x10 = 12'h014;
            4'h2: res_x10 = 12'h029;
            4'h3: res_x10 = 12'h053;
            4'h4: res_x10 = 12'h07A;
            4'h5: res_x10 = 12'h0AB;
            4'h6: res_x10 = 12'h100;
            4'h7: res_x10 = 12'h140;
            4'h8: res_x10 = 12'h16E;
            4'h9: res_x10 = 12'h1AB;
            4'hA: res_x10 = 12'h200;
            4'hB: res_x10 = 12'h280;
            4'hC: res_x10 = 12'h355;
            4'hD: res_x10 = 12'h500;
            4'hE: res_x10 = 12'hA00;
            default: res_x10 = 12'hFFF;
        endcase
    end
endmodule // rdt_res_decode

/* tb/rdt_chk.sv */
// checker for the drive resistance and edge timing bank
// assumes bind onto rdt_top, one clock domain
`timescale 1ns/10ps
module rdt_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire [2:0]  driver_speed,
    input wire [3:0]  antenna_driver_output_mod_code,
    input wire [3:0]  antenna_driver_output_idle_code,
    input wire        mod_hiz,
    input wire        idle_hiz,
    input wire        search_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_answer_next: assert property (
        psel && !penable |=> pready) else $error("no answer after setup");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready held too long");
    a_unmapped_err: assert property (
        pready && paddr == 12'h200 |-> pslverr) else $error("no error");
    a_mod_hiz: assert property (
        antenna_driver_output_mod_code == 4'hF |-> ##[0:2] mod_hiz)
        else $error("modulated code 15 not high-z");
    a_idle_hiz: assert property (
        antenna_driver_output_idle_code != 4'hF |-> ##[0:2] !idle_hiz)
        else $error("idle high-z on a plain code");
    a_start_slow: assert property (
        $rose(search_busy) |-> ##[0:2] driver_speed == 3'h0)
        else $error("search not started slowest");
    a_step_up: assert property (
        search_busy && $changed(driver_speed) && driver_speed != 3'h0
        |-> driver_speed == $past(driver_speed) + 3'h1)
        else $error("search skipped a speed");
    a_search_bound: assert property (
        $rose(search_busy) |-> ##[1:120] !search_busy)
        else $error("search too long");
    a_speed_range: assert property (
        driver_speed <= 3'h4) else $error("speed out of range");
endmodule // rdt_chk
bind rdt_top rdt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .driver_speed(driver_speed), .mod_hiz(mod_hiz), .idle_hiz(idle_hiz),
    .antenna_driver_output_mod_code(antenna_driver_output_mod_code),
    .antenna_driver_output_idle_code(antenna_driver_output_idle_code),
    .search_busy(search_busy));

/* tb/tb.sv */
// testbench for the drive resistance and edge timing bank
// assumes rdt_top alone; ratio rises by one per faster speed
`timescale 1ns/10ps
`include "rdt_defs.vh"
module tb;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, r;
    reg         e, driver_start = 0, rf_period_tick = 0;
    reg  [3:0]  measured_ratio = 0;
    reg  [1:0]  tk = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, mod_hiz, idle_hiz, search_busy;
    wire [2:0]  driver_speed;
    wire [3:0]  mc, ic;
    wire [11:0] mr, ir;
    integer     fail_count = 0, comparisons = 0, i;
    rdt_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .driver_start(driver_start), .rf_period_tick(rf_period_tick),
        .measured_ratio(measured_ratio), .driver_speed(driver_speed),
        .antenna_driver_output_mod_code(mc),
        .antenna_driver_output_idle_code(ic), .mod_res_x10(mr),
        .idle_res_x10(ir), .mod_hiz(mod_hiz), .idle_hiz(idle_hiz),
        .search_busy(search_busy));
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        tk <= tk + 2'h1;
        rf_period_tick <= (tk == 2'h3);
        measured_ratio <= {1'b0, driver_speed} + 4'h1;
    end
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr; psel <= 0; penable <= 0;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task t_reset;
        apb(0, `RDT_OFF_RES, 0); chk(r, 32'h70); chk(e, 0);
        apb(0, `RDT_OFF_TIM, 0); chk(r, 32'h7C);
        chk(driver_speed, `RDT_SPD_FAST); chk({mr, ir}, 24'h14000A);
        $display("reset test done");
    endtask
    task t_res;
        apb(1, `RDT_OFF_RES, 32'hFFFFFFF3); apb(0, `RDT_OFF_RES, 0);
        chk(r, 32'hF3);
        repeat (3) @(posedge pclk);
        chk({mod_hiz, idle_hiz, ir}, 14'h2053);
        chk({mc, ic}, 8'hF3);
        apb(1, `RDT_OFF_RES, 32'h0E); repeat (3) @(posedge pclk);
        chk({mod_hiz, idle_hiz, mr, ir}, 26'h00A_A00);
        $display("resistance test done");
    endtask
    task t_man;
        for (i = 0; i < 8; i = i + 1) begin
            apb(1, `RDT_OFF_TIM, 32'h78 | i); repeat (3) @(posedge pclk);
            chk(driver_speed, (i > 3) ? 3'h4 : i);
        end
        $display("manual test done");
    endtask
    task t_err;
        apb(1, `RDT_OFF_CTRL, 32'h55); chk(e, 1);
        apb(0, `RDT_OFF_CTRL, 0); chk({e, r}, 33'h100000000);
        apb(0, `RDT_OFF_RES, 0); chk(r, 32'h0E);
        $display("error test done");
    endtask
    task t_auto(input [3:0] tgt, input [2:0] spd);
        apb(1, `RDT_OFF_TIM, {tgt, 4'h0});
        driver_start <= 1; @(posedge pclk); driver_start <= 0;
        repeat (2) @(posedge pclk);
        chk(search_busy, 1);
        for (i = 0; i < 200 && search_busy; i = i + 1) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk(driver_speed, spd);
        apb(0, `RDT_OFF_STAT, 0); chk(r & 32'h3F, 32'h20 | spd);
        $display("auto test done");
    endtask
    task wrap_up;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t_reset; t_res; t_man; t_err;
        t_auto(4'h3, 3'h2); t_auto(4'hF, 3'h4); t_auto(4'h1, 3'h0);
        wrap_up;
    end
    initial begin
        #20000;
        fail_count = fail_count + 1;
        wrap_up;
    end
endmodule // tb
